// *** src/irps_map.svh ***
/*
  Register offsets, reset values and key pattern of the input route and
  port self-test block. Assumes a byte-addressed APB slave with 8 address bits.
*/
`ifndef IRPS_MAP_SVH
`define IRPS_MAP_SVH

// register byte offsets
`define IRPS_OFS_ROUTE1 8'h00
`define IRPS_OFS_ROUTE2 8'h04
`define IRPS_OFS_ROUTE3 8'h08
`define IRPS_OFS_ROUTE4 8'h0C
`define IRPS_OFS_SELFTEST 8'h10
`define IRPS_OFS_WAKE_EN 8'h14
`define IRPS_OFS_BITOP 8'h18
// port data at 0x20 + 4*port, port direction at 0x40 + 4*port
`define IRPS_REGION_DATA 3'h1
`define IRPS_REGION_CTRL 3'h2

// reset values
`define IRPS_ROUTE_RESET 8'h00
`define IRPS_ROUTE4_RESET 5'h00
`define IRPS_SELFTEST_RESET 8'h00
`define IRPS_WAKE_RESET 8'h00
`define IRPS_PORT_RESET 8'hFF

// pattern that turns the self-test read on
`define IRPS_SELFTEST_KEY 8'hCA

// number of ports A to G
`define IRPS_NUM_PORTS 7

`endif

// *** src/irps_pkg.sv ***
/*
  Types of the input route and port self-test block.
  Assumes the register map header is compiled alongside.
*/
package irps_pkg;

  // port letters, A first
  typedef enum logic [2:0] {port_a, port_b, port_c, port_d, port_e, port_f, port_g} irps_port_t;

  // one port byte
  typedef logic [7:0] irps_byte_t;

  // layout of a single-bit set or clear request
  typedef struct packed {
    logic target_ctrl; // 1: direction register, 0: data latch
    logic set_bit; // 1: set, 0: clear
    logic [2:0] port; // port letter
    logic [2:0] bit_idx; // bit within the port
  } irps_bitop_t;

endpackage : irps_pkg

// *** src/irps_sync.sv ***
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes each bit is an independent level; no bus coherence is promised.
*/
`timescale 1ns/1ps
module irps_sync #(
  parameter int WIDTH = 56
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : irps_sync

// *** src/irps_wake.sv ***
/*
  Port A wake-up detector: a falling level on an enabled pin while the
  core sleeps or idles raises a one-cycle wake request.
  Assumes the pin levels are already synchronised to pclk.
*/
`timescale 1ns/1ps
module irps_wake (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin levels and control
  input wire logic [7:0] porta_level,
  input wire logic [7:0] wake_enable,
  input wire logic low_power,
  // request
  output logic wake_request
);

  logic [7:0] prev_level;
  logic [7:0] falling;

  assign falling = prev_level & ~porta_level & wake_enable;

  // previous level, starts high like an idle pulled-up pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_level <= 8'hFF;
    else
      prev_level <= porta_level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_request <= 1'b0;
    else
      wake_request <= low_power & (|falling);
  end

  a_wake_falling: assert property (@(posedge pclk) disable iff (!presetn)
    (low_power && (|falling)) |=> wake_request)
    else $error("enabled falling edge did not wake");

  a_wake_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!low_power) |=> !wake_request)
    else $error("wake raised outside sleep or idle");

  c_wake_seen: cover property (@(posedge pclk) disable iff (!presetn) wake_request);

endmodule : irps_wake

// *** src/irps_top.sv ***
/*
  Input route selection and port self-test read block with its APB slave.
  Pins arrive asynchronously and are synchronised before use; the ADC
  channel, analog function selects and low-power level come from pclk logic.
*/
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "irps_map.svh"

// Behaviour
// - irq0 input from A6, F3, or B1 for codes two and three.
// - uart1 receive from A6,B1,D4,E7,F3,G5,A2,A6 by three-bit code.
// - uart0 receive from G6,A3,E3,F1, then G6 for codes four to seven.
// - periodic timer 0 capture from B2 when zero, B4 when one.
// - periodic timer 2 capture from E1 when zero, E4 when one.
// - standard timer capture from E2 when zero, E3 when one.
// - compact timer 0 clock from E7, F3, A6, and E7 for code three.
// - uart2 receive from A5,B3,E5,F7,G0, then A5 for higher codes.
// - two-wire data from ten listed pins, A2 for higher codes.
// - two-wire clock from ten listed pins, A0 for higher codes.
// - irq1 input from B7, E7, or B3 for codes two and three.
// - chip select from A2,A3,E7,F3,F7,G4,B3,E3 by three-bit code.
// - upper three bits of the fourth route register read zero.
// - self-test read on only while control holds 11001010.
// - self-test reads pins; otherwise inputs read pins, outputs read latch.
// - with self-test off, pins work as their selected shared function.
// - with self-test off, analog path open unless analog function chosen.
// - with self-test on, selected converter channel path is forced closed.
// - reset sets every port data and direction bit high.
// - single-bit set or clear reads the port, modifies, writes back.
// - in sleep or idle, enabled port A falling edge wakes.
module irps_top
  import irps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // port pins A to G, bit 8*port+n
  input wire logic [55:0] pin_in,
  output logic [55:0] pin_out,
  output logic [55:0] pin_oe,
  // analog converter side
  input wire logic [2:0] adc_channel,
  input wire logic [7:0] analog_func_sel,
  output logic [7:0] analog_path_on,
  // power state and wake
  input wire logic low_power,
  output logic wake_request,
  // routed peripheral inputs
  output logic external_irq0,
  output logic external_irq1,
  output logic uart0_rx_in,
  output logic uart1_rx_in,
  output logic uart2_rx_in,
  output logic ptimer0_capture_in,
  output logic ptimer2_capture_in,
  output logic stimer_capture_in,
  output logic ctimer0_clock_in,
  output logic serial_chip_select_in,
  output logic twowire_data_in,
  output logic twowire_clock_in,
  // self-test state for pin-shared muxes elsewhere
  output logic selftest_read_enable
);
  import irps_pkg::*;

  // level of one pin out of the flat vector
  function automatic logic pick(input logic [55:0] v, input irps_port_t p, input logic [2:0] b);
    return v[{p, b}];
  endfunction : pick

  logic [55:0] pin_s;
  irps_byte_t uart01_external_irq0_input_route;
  irps_byte_t timer_uart2_input_route;
  irps_byte_t twowire_input_route;
  logic [4:0] external_irq1_chipselect_input_route;
  irps_byte_t selftest_read_control;
  irps_byte_t wake_enable;
  irps_byte_t port_data [`IRPS_NUM_PORTS];
  irps_byte_t port_ctrl [`IRPS_NUM_PORTS];
  logic setup_phase;
  logic write_hit;
  logic [2:0] region;
  logic [2:0] port_idx;
  logic port_ok;
  logic mapped;
  logic [31:0] next_prdata;
  irps_bitop_t bitop;
  irps_byte_t rmw_view;
  irps_byte_t rmw_value;

  // pin levels synchronised before any use
  irps_sync #(.WIDTH(56)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(pin_s)
  );

  // port A wake-up
  irps_wake u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .porta_level(pin_s[7:0]),
    .wake_enable(wake_enable),
    .low_power(low_power),
    .wake_request(wake_request)
  );

  assign selftest_read_enable = (selftest_read_control == `IRPS_SELFTEST_KEY);

  // value a port read returns
  function automatic irps_byte_t port_view(input logic st, input irps_byte_t pins,
                                           input irps_byte_t ctrl, input irps_byte_t data);
    if (st)
      return pins;
    return (ctrl & pins) | (~ctrl & data);
  endfunction : port_view

  // apb decode
  assign region = paddr[7:5];
  assign port_idx = paddr[4:2];
  assign port_ok = (port_idx < 3'(`IRPS_NUM_PORTS)) && (paddr[1:0] == 2'h0);
  assign setup_phase = psel & ~penable;
  assign pready = psel & penable;
  assign write_hit = psel & penable & pwrite & ~pslverr;
  assign bitop = irps_bitop_t'(pwdata[7:0]);

  // read mux and map check for the addressed word
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (region == `IRPS_REGION_DATA && port_ok)
      next_prdata[7:0] = port_view(selftest_read_enable, pin_s[{port_idx, 3'h0} +: 8],
                                   port_ctrl[port_idx], port_data[port_idx]);
    else if (region == `IRPS_REGION_CTRL && port_ok)
      next_prdata[7:0] = port_ctrl[port_idx];
    else
    begin
      case (paddr)
        `IRPS_OFS_ROUTE1: next_prdata[7:0] = uart01_external_irq0_input_route;
        `IRPS_OFS_ROUTE2: next_prdata[7:0] = timer_uart2_input_route;
        `IRPS_OFS_ROUTE3: next_prdata[7:0] = twowire_input_route;
        `IRPS_OFS_ROUTE4: next_prdata[4:0] = external_irq1_chipselect_input_route;
        `IRPS_OFS_SELFTEST: next_prdata[7:0] = selftest_read_control;
        `IRPS_OFS_WAKE_EN: next_prdata[7:0] = wake_enable;
        `IRPS_OFS_BITOP: next_prdata = 32'h0000_0000;
        default: mapped = 1'b0;
      endcase
    end
  end

  // read data and error captured in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~mapped;
    end
  end

  // route and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uart01_external_irq0_input_route <= `IRPS_ROUTE_RESET;
      timer_uart2_input_route <= `IRPS_ROUTE_RESET;
      twowire_input_route <= `IRPS_ROUTE_RESET;
      external_irq1_chipselect_input_route <= `IRPS_ROUTE4_RESET;
      selftest_read_control <= `IRPS_SELFTEST_RESET;
      wake_enable <= `IRPS_WAKE_RESET;
    end
    else if (write_hit)
    begin
      case (paddr)
        `IRPS_OFS_ROUTE1: uart01_external_irq0_input_route <= pwdata[7:0];
        `IRPS_OFS_ROUTE2: timer_uart2_input_route <= pwdata[7:0];
        `IRPS_OFS_ROUTE3: twowire_input_route <= pwdata[7:0];
        `IRPS_OFS_ROUTE4: external_irq1_chipselect_input_route <= pwdata[4:0];
        // any other value clears the enable
        `IRPS_OFS_SELFTEST: selftest_read_control <= pwdata[7:0];
        `IRPS_OFS_WAKE_EN: wake_enable <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read side of a single-bit request
  always_comb
  begin
    rmw_view = 8'h00;
    rmw_value = 8'h00;
    if (bitop.port < 3'(`IRPS_NUM_PORTS))
    begin
      if (bitop.target_ctrl)
        rmw_view = port_ctrl[bitop.port];
      else
        rmw_view = port_view(selftest_read_enable, pin_s[{bitop.port, 3'h0} +: 8],
                             port_ctrl[bitop.port], port_data[bitop.port]);
      rmw_value = rmw_view;
      rmw_value[bitop.bit_idx] = bitop.set_bit;
    end
  end

  // port data latches and direction bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // all ports start high, as inputs
      for (int i = 0; i < `IRPS_NUM_PORTS; i++)
      begin
        port_data[i] <= `IRPS_PORT_RESET;
        port_ctrl[i] <= `IRPS_PORT_RESET;
      end
    end
    else if (write_hit)
    begin
      if (region == `IRPS_REGION_DATA && port_ok)
        port_data[port_idx] <= pwdata[7:0];
      else if (region == `IRPS_REGION_CTRL && port_ok)
        port_ctrl[port_idx] <= pwdata[7:0];
      else if (paddr == `IRPS_OFS_BITOP && bitop.port < 3'(`IRPS_NUM_PORTS))
      begin
        if (bitop.target_ctrl)
          port_ctrl[bitop.port] <= rmw_value;
        else
          port_data[bitop.port] <= rmw_value;
      end
    end
  end

  // pins follow latch and direction; shared muxes use the enable
  always_comb
  begin
    pin_out = 56'h0;
    pin_oe = 56'h0;
    for (int i = 0; i < `IRPS_NUM_PORTS; i++)
    begin
      pin_out[i*8 +: 8] = port_data[i];
      pin_oe[i*8 +: 8] = ~port_ctrl[i]; // direction 0 drives
    end
  end

  // analog switch control on port A pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_path_on <= 8'h00;
    else if (selftest_read_enable)
      analog_path_on <= analog_func_sel | (8'h01 << adc_channel);
    else
      analog_path_on <= analog_func_sel;
  end

  // pin index for each route code, bit 8*port+n; unused codes repeat the code-zero pin, code two for irq0 and irq1
  localparam logic [5:0] IRQ0_PIN [4] = '{6'h06, 6'h2B, 6'h09, 6'h09};
  localparam logic [5:0] UART1_PIN [8] = '{6'h06, 6'h09, 6'h1C, 6'h27, 6'h2B, 6'h35, 6'h02, 6'h06};
  localparam logic [5:0] UART0_PIN [8] = '{6'h36, 6'h03, 6'h23, 6'h29, 6'h36, 6'h36, 6'h36, 6'h36};
  localparam logic [5:0] CT0_PIN [4] = '{6'h27, 6'h2B, 6'h06, 6'h27};
  localparam logic [5:0] UART2_PIN [8] = '{6'h05, 6'h0B, 6'h25, 6'h2F, 6'h30, 6'h05, 6'h05, 6'h05};
  localparam logic [5:0] TWD_PIN [16] = '{6'h02, 6'h01, 6'h08, 6'h0A, 6'h16, 6'h24, 6'h28, 6'h2E,
                                          6'h2F, 6'h32, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02};
  localparam logic [5:0] TWC_PIN [16] = '{6'h00, 6'h07, 6'h09, 6'h0B, 6'h17, 6'h25, 6'h29, 6'h2F,
                                          6'h2E, 6'h33, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
  localparam logic [5:0] IRQ1_PIN [4] = '{6'h0F, 6'h27, 6'h0B, 6'h0B};
  localparam logic [5:0] CS_PIN [8] = '{6'h02, 6'h03, 6'h27, 6'h2B, 6'h2F, 6'h34, 6'h0B, 6'h23};

  // routed inputs, one register stage after the synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {external_irq0, external_irq1, uart0_rx_in, uart1_rx_in, uart2_rx_in, ptimer0_capture_in,
       ptimer2_capture_in, stimer_capture_in, ctimer0_clock_in, serial_chip_select_in,
       twowire_data_in, twowire_clock_in} <= 12'h000;
    else
    begin
      external_irq0 <= pin_s[IRQ0_PIN[uart01_external_irq0_input_route[7:6]]]; // A6 F3 B1 B1
      uart1_rx_in <= pin_s[UART1_PIN[uart01_external_irq0_input_route[5:3]]]; // A6 B1 D4 E7 F3 G5 A2 A6
      uart0_rx_in <= pin_s[UART0_PIN[uart01_external_irq0_input_route[2:0]]]; // G6 A3 E3 F1, then G6
      ptimer0_capture_in <= timer_uart2_input_route[7] ? pick(pin_s, port_b, 3'h4) : pick(pin_s, port_b, 3'h2);
      ptimer2_capture_in <= timer_uart2_input_route[6] ? pick(pin_s, port_e, 3'h4) : pick(pin_s, port_e, 3'h1);
      stimer_capture_in <= timer_uart2_input_route[5] ? pick(pin_s, port_e, 3'h3) : pick(pin_s, port_e, 3'h2);
      ctimer0_clock_in <= pin_s[CT0_PIN[timer_uart2_input_route[4:3]]]; // E7 F3 A6 E7
      uart2_rx_in <= pin_s[UART2_PIN[timer_uart2_input_route[2:0]]]; // A5 B3 E5 F7 G0, then A5
      twowire_data_in <= pin_s[TWD_PIN[twowire_input_route[7:4]]]; // ten pins, then A2
      twowire_clock_in <= pin_s[TWC_PIN[twowire_input_route[3:0]]]; // ten pins, then A0
      external_irq1 <= pin_s[IRQ1_PIN[external_irq1_chipselect_input_route[4:3]]]; // B7 E7 B3 B3
      serial_chip_select_in <= pin_s[CS_PIN[external_irq1_chipselect_input_route[2:0]]]; // A2 A3 E7 F3 F7 G4 B3 E3
    end
  end

  // checks on routing, self-test and port behaviour
  a_irq0_shared: assert property (@(posedge pclk) disable iff (!presetn)
    (uart01_external_irq0_input_route[7:6] == 2'h3) |=> external_irq0 == $past(pin_s[9]))
    else $error("irq0 code 11 not routed from B1");
  a_uart0_high: assert property (@(posedge pclk) disable iff (!presetn)
    (uart01_external_irq0_input_route[2] == 1'b1) |=> uart0_rx_in == $past(pin_s[54]))
    else $error("uart0 high code not routed from G6");
  a_ctimer_code3: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_uart2_input_route[4:3] == 2'h3) |=> ctimer0_clock_in == $past(pin_s[39]))
    else $error("compact timer clock code 11 not from E7");
  a_twowire_unused: assert property (@(posedge pclk) disable iff (!presetn)
    (twowire_input_route == 8'hCC) |=> (twowire_data_in == $past(pin_s[2]))
                                       && (twowire_clock_in == $past(pin_s[0])))
    else $error("two-wire code 1100 not on default pins");
  a_route4_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == `IRPS_OFS_ROUTE4) |=> prdata[31:5] == 27'h0)
    else $error("fourth route register upper bits not zero");
  a_selftest_key: assert property (@(posedge pclk) disable iff (!presetn)
    (write_hit && paddr == `IRPS_OFS_SELFTEST) |=>
      selftest_read_enable == ($past(pwdata[7:0]) == 8'hCA))
    else $error("self-test enable disagrees with written pattern");
  a_port_read_mix: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && paddr == 8'h20 && !selftest_read_enable) |=>
      prdata[7:0] == $past((port_ctrl[0] & pin_s[7:0]) | (~port_ctrl[0] & port_data[0])))
    else $error("port A read mixes pins and latch wrongly");
  a_analog_forced: assert property (@(posedge pclk) disable iff (!presetn)
    selftest_read_enable |=> analog_path_on[$past(adc_channel)])
    else $error("selected channel path not forced on");
  a_analog_open: assert property (@(posedge pclk) disable iff (!presetn)
    !selftest_read_enable |=> analog_path_on == $past(analog_func_sel))
    else $error("analog path on without analog function");
  a_rmw_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (write_hit && paddr == `IRPS_OFS_BITOP && bitop.target_ctrl && bitop.port == 3'h1) |=>
      port_ctrl[1][$past(bitop.bit_idx)] == $past(bitop.set_bit))
    else $error("bit set or clear lost on port B direction");
  c_selftest_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(selftest_read_enable));
  c_bitop_write: cover property (@(posedge pclk) disable iff (!presetn) write_hit && paddr == `IRPS_OFS_BITOP);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule : irps_top

// *** test/irps_pins.sv ***
/* pad model standing at the pins of the route block.
   assumes ext and fight come from the bench. */
`timescale 1ns/1ps
module irps_pins (
  // block side
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe,
  // far side
  input wire logic [55:0] ext,
  input wire logic [55:0] fight,
  output logic [55:0] pin_in
);
  // a driven pin echoes its latch unless an outside driver fights it
  assign pin_in = (pin_oe & ~fight & pin_out) | (~(pin_oe & ~fight) & ext);
endmodule : irps_pins

// *** test/input_route_and_port_selftest_test.sv ***
/* self-checking bench for the input route and port self-test block.
   assumes a zero-wait APB slave and the pad model. */
`timescale 1ns/1ps
module input_route_and_port_selftest_test;
  import irps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_power, wake_request, st_en, err;
  logic [7:0] paddr, q, analog_func_sel, analog_path_on;
  logic [2:0] adc_channel;
  logic [31:0] pwdata, prdata;
  logic [55:0] pin_in, pin_out, pin_oe, ext, fight;
  logic [11:0] outs;
  int num_errors, checks;
  // rows: address, data, pin index, routed output index
  logic [31:0] rows [21] = '{32'h00402B00, 32'h00800900, 32'h00300202, 32'h00380602,
    32'h00032903, 32'h00073603, 32'h04800C05, 32'h04402406,
    32'h04202307, 32'h04100608, 32'h04182708, 32'h04043004,
    32'h04050504, 32'h0890320A, 32'h08CC020A, 32'h08082E0B,
    32'h080C000B, 32'h0C082701, 32'h0C053409, 32'h0C072309, 32'h00C00900};

  irps_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .adc_channel(adc_channel),
    .analog_func_sel(analog_func_sel), .analog_path_on(analog_path_on), .low_power(low_power),
    .wake_request(wake_request), .external_irq0(outs[0]), .external_irq1(outs[1]),
    .uart1_rx_in(outs[2]), .uart0_rx_in(outs[3]), .uart2_rx_in(outs[4]), .ptimer0_capture_in(outs[5]),
    .ptimer2_capture_in(outs[6]), .stimer_capture_in(outs[7]), .ctimer0_clock_in(outs[8]),
    .serial_chip_select_in(outs[9]), .twowire_data_in(outs[10]), .twowire_clock_in(outs[11]),
    .selftest_read_enable(st_en));
  irps_pins pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .fight(fight), .pin_in(pin_in));

  // free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic conclude;
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    q = prdata[7:0];
    err = pslverr;
    if (pready !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // main sequence
  initial
  begin
    int n;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    low_power = 1'b0; adc_channel = 3'h3; analog_func_sel = 8'h00; ext = '0; fight = '0;
    num_errors = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    chk(pin_out, {56{1'b1}});
    chk(pin_oe, 56'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h40, 8'h00);
    chk(q, 8'hFF);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i][31:24], rows[i][23:16]);
      ext <= 56'h1 << rows[i][15:8];
      repeat (4) @(posedge pclk);
      chk(outs[rows[i][3:0]], 1'b1);
      ext <= '0;
      repeat (4) @(posedge pclk);
      chk(outs[rows[i][3:0]], 1'b0);
    end
    apb(1'b1, 8'h0C, 8'hFF);
    apb(1'b0, 8'h0C, 8'h00);
    chk(q, 8'h1F);
    apb(1'b0, 8'h3C, 8'h00);
    chk({err, q}, 9'h100);
    // port B driven low-nibble high while an outside driver forces A5
    apb(1'b1, 8'h44, 8'h00);
    apb(1'b1, 8'h24, 8'h0F);
    fight[15:8] <= 8'hFF;
    ext[15:8] <= 8'hA5;
    ext[23:16] <= 8'h3C;
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h24, 8'h00);
    chk(q, 8'h0F);
    chk(analog_path_on, 8'h00);
    // port A is all inputs with its pins low
    apb(1'b0, 8'h20, 8'h00);
    chk(q, 8'h00);
    apb(1'b1, 8'h10, 8'hCA);
    chk(st_en, 1'b1);
    apb(1'b0, 8'h24, 8'h00);
    chk(q, 8'hA5);
    chk(analog_path_on, 8'h08);
    // self-test turned off once its checks are done
    apb(1'b1, 8'h10, 8'hCB);
    chk(st_en, 1'b0);
    analog_func_sel <= 8'h01;
    repeat (2) @(posedge pclk);
    chk(analog_path_on, 8'h01);
    // set bit 0 of port C: pins read 3C, so latch becomes 3D
    apb(1'b1, 8'h18, 8'h50);
    chk(pin_out[23:16], 8'h3D);
    // set bit 2 of port B direction: 00 becomes 04
    apb(1'b1, 8'h18, 8'hCA);
    apb(1'b0, 8'h44, 8'h00);
    chk(q, 8'h04);
    apb(1'b1, 8'h14, 8'h01);
    ext[0] <= 1'b1;
    low_power <= 1'b1;
    repeat (4) @(posedge pclk);
    ext[0] <= 1'b0;
    for (n = 0; n < 10 && wake_request !== 1'b1; n++)
    begin
      @(posedge pclk);
      #1;
    end
    chk(wake_request, 1'b1);
    // a second reset in mid-run restores every port
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pin_out, {56{1'b1}});
    chk(pin_oe, 56'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h48, 8'h00);
    chk(q, 8'hFF);
    conclude();
  end
endmodule : input_route_and_port_selftest_test
